// file: src/pfc_alu.sv
// Eight-bit arithmetic-logic unit with status flag update
`timescale 1ns/1ps
`default_nettype none
module pfc_alu (
	input wire pfc_pkg::pfc_alu_req_t req_in,
	output pfc_pkg::pfc_alu_res_t res_out
);
	import pfc_pkg::*;

	logic [8:0] sum9; // Adder with carry out
	logic [4:0] half5; // Low nibble adder for auxiliary carry
	logic [7:0] addend; // True or inverted second operand
	logic cin; // Carry into the adder
	logic [8:0] adj9; // Decimal adjust sum
	logic [7:0] adj; // Decimal adjust amount

	// Shared adder serves add, subtract and their carry forms
	always_comb begin
		addend = req_in.b;
		cin = 1'b0;
		case (req_in.func)
			ALU_ADC: cin = req_in.st.c;
			ALU_SUB: begin
				addend = ~req_in.b;
				cin = 1'b1;
			end
			ALU_SBC: begin
				addend = ~req_in.b;
				cin = req_in.st.c;
			end
			default: cin = 1'b0;
		endcase
		sum9 = {1'b0, req_in.a} + {1'b0, addend} + {8'h00, cin};
		half5 = {1'b0, req_in.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
	end

	// Decimal adjust of the accumulator after a packed BCD add
	always_comb begin
		adj = 8'h00;
		if (req_in.a[3:0] > 4'h9 || req_in.st.ac) begin
			adj[3:0] = 4'h6;
		end
		if (req_in.a[7:4] > 4'h9 || req_in.st.c) begin
			adj[7:4] = 4'h6;
		end
		adj9 = {1'b0, req_in.a} + {1'b0, adj};
	end

	// Result select and flag update, only touched flags change
	always_comb begin
		res_out.result = req_in.b;
		res_out.st = req_in.st;
		case (req_in.func)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				res_out.result = sum9[7:0];
				res_out.st.c = sum9[8]; // Set means no borrow on subtract
				res_out.st.ac = half5[4];
				res_out.st.ov = (req_in.a[7] == addend[7]) &&
					(sum9[7] != req_in.a[7]);
			end
			ALU_DAA: begin
				res_out.result = adj9[7:0];
				res_out.st.c = adj9[8] | req_in.st.c;
			end
			ALU_AND: res_out.result = req_in.a & req_in.b;
			ALU_OR: res_out.result = req_in.a | req_in.b;
			ALU_XOR: res_out.result = req_in.a ^ req_in.b;
			ALU_CPL: res_out.result = ~req_in.b;
			ALU_RR: res_out.result = {req_in.b[0], req_in.b[7:1]};
			ALU_RRC: begin
				res_out.result = {req_in.st.c, req_in.b[7:1]};
				res_out.st.c = req_in.b[0];
			end
			ALU_RL: res_out.result = {req_in.b[6:0], req_in.b[7]};
			ALU_RLC: begin
				res_out.result = {req_in.b[6:0], req_in.st.c};
				res_out.st.c = req_in.b[7];
			end
			ALU_INC: res_out.result = req_in.b + 8'h01;
			ALU_DEC: res_out.result = req_in.b - 8'h01;
			default: res_out.result = req_in.b;
		endcase
		// Rotates, decimal adjust and pass leave zero alone; the rest set it
		if (req_in.func != ALU_RR && req_in.func != ALU_RRC &&
			req_in.func != ALU_RL && req_in.func != ALU_RLC &&
			req_in.func != ALU_DAA && req_in.func != ALU_PASS) begin
			res_out.st.z = (res_out.result == 8'h00);
		end
	end

endmodule
`default_nettype wire

// file: src/pfc_core.sv
// Program-flow core: phases, pipeline, program counter, stack, ALU use
`timescale 1ns/1ps
`default_nettype none
module pfc_core #(
	parameter logic [pfc_pkg::PC_W-1:0] INT_VECTOR =
		pfc_pkg::INT_VECTOR_DEFAULT
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	output logic [3:0] phase_clocks_out,
	output logic [pfc_pkg::PC_W-1:0] pmem_addr_out,
	input wire logic [15:0] pmem_data_in,
	input wire logic int_req_in,
	output logic int_ack_out,
	output logic stack_full_out,
	input wire logic [pfc_pkg::BUS_ADDR_W-1:0] bus_addr_in,
	input wire logic [pfc_pkg::DATA_W-1:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [pfc_pkg::DATA_W-1:0] bus_rdata_out
);
	import pfc_pkg::*;

	pfc_phase_t phase_reg; // Current phase
	logic [3:0] phase_clocks_reg; // One-hot phase strobes
	logic [PC_W-1:0] pc_reg; // Address of the next word to fetch
	logic [15:0] fetch_reg; // Prefetched word, not yet executing
	logic [PC_W-1:0] fetch_addr_reg; // Where the prefetched word came from
	logic [15:0] ir_reg; // Word executing this cycle
	logic ir_valid_reg; // Low for a dummy cycle
	logic flush_reg; // The prefetched word is on a dead path
	logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // Return addresses only
	logic [SP_W-1:0] sp_reg; // Next free stack slot
	logic [3:0] depth_reg; // Occupied levels, saturates at eight
	logic stack_full_reg; // All levels occupied
	logic [DATA_W-1:0] regs [16]; // Data registers addressed by ALU ops
	logic [DATA_W-1:0] acc_reg; // Accumulator
	pfc_status_t status_reg; // Status flags
	logic int_en_reg; // Global interrupt enable
	logic int_pend_reg; // Recorded interrupt request
	logic int_ack_reg; // Acknowledge strobe
	logic pcl_pend_reg; // Software low byte write awaiting execution
	logic [DATA_W-1:0] pcl_val_reg; // Value of that write
	logic [DATA_W-1:0] rdata_reg; // Read data, valid one cycle after strobe

	logic [3:0] grp; // Instruction group
	logic exec; // Execution point of a live instruction
	logic ctrl_op; // Live instruction changes program flow
	logic redirect; // Counter is loaded this cycle
	logic [PC_W-1:0] target; // Value loaded on redirect
	logic push; // Stack push this cycle
	logic pop; // Stack pop this cycle
	logic [PC_W-1:0] push_val; // Address pushed
	logic [PC_W-1:0] stack_top; // Most recent saved address
	logic ack_go; // Interrupt acknowledged this cycle
	logic bus_jump; // Software low byte write takes effect
	logic skip_take; // Skip condition met
	logic [DATA_W-1:0] operand; // Register operand of the instruction
	logic wr_dest; // Result is written back
	pfc_alu_req_t alu_req; // Operation to the ALU
	pfc_alu_res_t alu_res; // ALU answer

	assign phase_clocks_out = phase_clocks_reg;
	assign pmem_addr_out = pc_reg;
	assign int_ack_out = int_ack_reg;
	assign stack_full_out = stack_full_reg;
	assign bus_rdata_out = rdata_reg;

	assign grp = ir_reg[15:12];
	assign exec = (phase_reg == PH_T4) && ir_valid_reg;
	assign stack_top = stack_mem[sp_reg - 3'h1];
	assign wr_dest = exec && ir_reg[3:0] != REG_PCL_ALIAS &&
		((grp == GRP_ALU && ir_reg[7]) ||
		(grp == GRP_SKIP && ir_reg[9]));

	// Phase sequencer, one phase per clock, four make a cycle
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			phase_reg <= PH_T1;
			phase_clocks_reg <= 4'h1;
		end else begin
			case (phase_reg)
				PH_T1: phase_reg <= PH_T2;
				PH_T2: phase_reg <= PH_T3;
				PH_T3: phase_reg <= PH_T4;
				PH_T4: phase_reg <= PH_T1;
				default: phase_reg <= PH_T1;
			endcase
			// Strobes lead the code by one so they line up with it
			case (phase_reg)
				PH_T1: phase_clocks_reg <= 4'h2;
				PH_T2: phase_clocks_reg <= 4'h4;
				PH_T3: phase_clocks_reg <= 4'h8;
				default: phase_clocks_reg <= 4'h1;
			endcase
		end
	end

	// Operand fetch; the alias index reads the counter low byte
	always_comb begin
		if (ir_reg[3:0] == REG_PCL_ALIAS) begin
			operand = pc_reg[7:0];
		end else begin
			operand = regs[ir_reg[3:0]];
		end
	end

	// ALU request built from the executing word
	always_comb begin
		alu_req.a = acc_reg;
		alu_req.b = operand;
		alu_req.st = status_reg;
		alu_req.func = pfc_alu_func_t'(ir_reg[11:8]);
		if (grp == GRP_SKIP) begin
			case (ir_reg[9:8])
				SKIP_INC_ZERO: alu_req.func = ALU_INC;
				SKIP_DEC_ZERO: alu_req.func = ALU_DEC;
				default: alu_req.func = ALU_PASS;
			endcase
		end
	end

	pfc_alu u_alu (
		.req_in(alu_req),
		.res_out(alu_res)
	);

	// Skip decision from the ALU result
	always_comb begin
		case (ir_reg[9:8])
			SKIP_NONZERO: skip_take = (alu_res.result != 8'h00);
			default: skip_take = (alu_res.result == 8'h00);
		endcase
	end

	// Flow decision at the last phase; live instruction beats software
	// jump, which beats the interrupt, so none is lost by a clash
	always_comb begin
		ctrl_op = 1'b0;
		redirect = 1'b0;
		target = pc_reg;
		push = 1'b0;
		pop = 1'b0;
		push_val = fetch_addr_reg;
		ack_go = 1'b0;
		bus_jump = 1'b0;
		if (exec) begin
			case (grp)
				GRP_JUMP, GRP_CALL: begin
					ctrl_op = 1'b1;
					redirect = 1'b1;
					target = ir_reg[11:0];
					push = (grp == GRP_CALL);
				end
				GRP_SUB_RET, GRP_INT_RET: begin
					ctrl_op = 1'b1;
					redirect = 1'b1;
					pop = 1'b1;
					target = stack_top;
				end
				GRP_SKIP: begin
					ctrl_op = skip_take;
					redirect = skip_take; // Counter kept, word dropped
				end
				GRP_ALU: begin
					if (ir_reg[7] && ir_reg[3:0] == REG_PCL_ALIAS) begin
						ctrl_op = 1'b1;
						redirect = 1'b1;
						target = {pc_reg[11:8], alu_res.result};
					end
				end
				default: ctrl_op = 1'b0;
			endcase
		end
		if (exec && !ctrl_op) begin
			if (pcl_pend_reg) begin
				bus_jump = 1'b1;
				redirect = 1'b1;
				target = {pc_reg[11:8], pcl_val_reg};
			end else if (int_pend_reg && int_en_reg && !stack_full_reg) begin
				// Full stack withholds acknowledge, flag stays
				ack_go = 1'b1;
				redirect = 1'b1;
				push = 1'b1; // Return to the prefetched word
				target = INT_VECTOR;
			end
		end
	end

	// Pipeline: fetch and count at the first phase, load on redirect
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pc_reg <= PC_RESET;
			fetch_reg <= WORD_RESET;
			fetch_addr_reg <= PC_RESET;
			ir_reg <= WORD_RESET;
			ir_valid_reg <= 1'b0;
			flush_reg <= 1'b1; // First cycle is a dummy while vector loads
		end else if (phase_reg == PH_T1) begin
			ir_reg <= fetch_reg; // Execute last fetch, fetch next
			ir_valid_reg <= !flush_reg; // Dead word becomes dummy
			fetch_reg <= pmem_data_in;
			fetch_addr_reg <= pc_reg;
			pc_reg <= pc_reg + 12'h001;
			flush_reg <= 1'b0;
		end else if (redirect) begin
			pc_reg <= target;
			flush_reg <= 1'b1; // Costs one more cycle
		end
	end

	// Return stack, circular so overflow drops the oldest
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			sp_reg <= SP_RESET;
			depth_reg <= DEPTH_RESET;
			stack_full_reg <= 1'b0;
		end else if (push) begin
			stack_mem[sp_reg] <= push_val;
			sp_reg <= sp_reg + 3'h1; // Wraps over oldest
			if (depth_reg != DEPTH_FULL) begin
				depth_reg <= depth_reg + 4'h1;
			end
			stack_full_reg <= (depth_reg >= DEPTH_FULL - 4'h1);
		end else if (pop) begin
			sp_reg <= sp_reg - 3'h1; // Frees a level
			if (depth_reg != DEPTH_RESET) begin
				depth_reg <= depth_reg - 4'h1;
			end
			stack_full_reg <= 1'b0;
		end
	end

	// Data registers and accumulator; instruction write wins over
	// a software write in the same cycle
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			acc_reg <= BYTE_RESET;
		end else if (exec && grp == GRP_MOVI) begin
			acc_reg <= ir_reg[7:0];
		end else if (exec && grp == GRP_ALU && !ir_reg[7]) begin
			acc_reg <= alu_res.result;
		end else if (bus_wr_in && bus_addr_in == IDX_ACC) begin
			acc_reg <= bus_wdata_in;
		end
		if (wr_dest) begin
			regs[ir_reg[3:0]] <= alu_res.result;
		end
	end

	// Status flags follow every ALU operation
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			status_reg <= '0;
		end else if (exec && (grp == GRP_ALU || grp == GRP_SKIP)) begin
			status_reg <= alu_res.st;
		end else if (bus_wr_in && bus_addr_in == IDX_STATUS) begin
			status_reg <= bus_wdata_in[3:0];
		end
	end

	// Interrupt request, enable and acknowledge strobe
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			int_pend_reg <= 1'b0;
			int_en_reg <= 1'b0;
			int_ack_reg <= 1'b0;
		end else begin
			int_ack_reg <= ack_go;
			// A new request in the acknowledge cycle is kept
			if (int_req_in) begin
				int_pend_reg <= 1'b1;
			end else if (ack_go) begin
				int_pend_reg <= 1'b0;
			end
			if (ack_go) begin
				int_en_reg <= 1'b0; // No nesting until interrupt return or a control write
			end else if (exec && grp == GRP_INT_RET) begin
				int_en_reg <= 1'b1;
			end else if (bus_wr_in && bus_addr_in == IDX_CTRL) begin
				int_en_reg <= bus_wdata_in[CTRL_INT_EN_BIT];
			end
		end
	end

	// Software low byte write is held until an execution point with no flow change
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pcl_pend_reg <= 1'b0;
			pcl_val_reg <= BYTE_RESET;
		end else if (bus_wr_in && bus_addr_in == IDX_PC_LOW_BYTE) begin
			pcl_pend_reg <= 1'b1; // New write wins over consumption
			pcl_val_reg <= bus_wdata_in;
		end else if (bus_jump) begin
			pcl_pend_reg <= 1'b0;
		end
	end

	// Register port reads; stack and pointer have no address
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			rdata_reg <= BYTE_RESET;
		end else if (bus_rd_in) begin
			case (bus_addr_in)
				IDX_PC_LOW_BYTE: rdata_reg <= pc_reg[7:0];
				IDX_STATUS: rdata_reg <= {4'h0, status_reg};
				IDX_ACC: rdata_reg <= acc_reg;
				IDX_CTRL: begin
					rdata_reg <= BYTE_RESET;
					rdata_reg[CTRL_INT_EN_BIT] <= int_en_reg;
					rdata_reg[CTRL_PEND_BIT] <= int_pend_reg;
					rdata_reg[CTRL_FULL_BIT] <= stack_full_reg;
				end
				default: rdata_reg <= BYTE_RESET; // Unmapped reads zero
			endcase
		end else begin
			rdata_reg <= BYTE_RESET;
		end
	end

endmodule
`default_nettype wire

// file: src/pfc_pkg.sv
// Shared constants, encodings and carriers of the program-flow core
package pfc_pkg;

	// Program counter, stack, data, register index and port address sizes
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam int DATA_W = 8;
	localparam int REG_IDX_W = 4;
	localparam int BUS_ADDR_W = 4;

	// Values after reset, the full stack depth and the default interrupt vector
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [SP_W-1:0] SP_RESET = 3'h0;
	localparam logic [3:0] DEPTH_RESET = 4'h0;
	localparam logic [3:0] DEPTH_FULL = 4'h8;
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [PC_W-1:0] INT_VECTOR_DEFAULT = 12'h004;

	// Register port indices
	localparam logic [BUS_ADDR_W-1:0] IDX_PC_LOW_BYTE = 4'h0;
	localparam logic [BUS_ADDR_W-1:0] IDX_STATUS = 4'h1;
	localparam logic [BUS_ADDR_W-1:0] IDX_ACC = 4'h2;
	localparam logic [BUS_ADDR_W-1:0] IDX_CTRL = 4'h3;

	// Control register bit positions
	localparam int CTRL_INT_EN_BIT = 0;
	localparam int CTRL_PEND_BIT = 1;
	localparam int CTRL_FULL_BIT = 2;

	// Data register index that aliases the program counter low byte
	localparam logic [REG_IDX_W-1:0] REG_PCL_ALIAS = 4'hf;

	// Instruction groups in bits 15:12
	localparam logic [3:0] GRP_NOP = 4'h0;
	localparam logic [3:0] GRP_ALU = 4'h1;
	localparam logic [3:0] GRP_MOVI = 4'h2;
	localparam logic [3:0] GRP_JUMP = 4'h3;
	localparam logic [3:0] GRP_CALL = 4'h4;
	localparam logic [3:0] GRP_SUB_RET = 4'h5;
	localparam logic [3:0] GRP_INT_RET = 4'h6;
	localparam logic [3:0] GRP_SKIP = 4'h7;

	// Skip kinds in bits 9:8 of a skip instruction
	localparam logic [1:0] SKIP_ZERO = 2'h0;
	localparam logic [1:0] SKIP_NONZERO = 2'h1;
	localparam logic [1:0] SKIP_INC_ZERO = 2'h2;
	localparam logic [1:0] SKIP_DEC_ZERO = 2'h3;

	// Phase codes of one instruction cycle
	typedef enum logic [1:0] {
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b10,
		PH_T4 = 2'b11
	} pfc_phase_t;

	// Arithmetic-logic functions
	typedef enum logic [3:0] {
		ALU_ADD = 4'h0,
		ALU_ADC = 4'h1,
		ALU_SUB = 4'h2,
		ALU_SBC = 4'h3,
		ALU_DAA = 4'h4,
		ALU_AND = 4'h5,
		ALU_OR = 4'h6,
		ALU_XOR = 4'h7,
		ALU_CPL = 4'h8,
		ALU_RR = 4'h9,
		ALU_RRC = 4'ha,
		ALU_RL = 4'hb,
		ALU_RLC = 4'hc,
		ALU_INC = 4'hd,
		ALU_DEC = 4'he,
		ALU_PASS = 4'hf
	} pfc_alu_func_t;

	// Status flags, kept in the low nibble of the status register
	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
	} pfc_status_t;

	// Operation handed to the arithmetic-logic unit
	typedef struct packed {
		pfc_alu_func_t func;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
		pfc_status_t st;
	} pfc_alu_req_t;

	// Result and flag update coming back
	typedef struct packed {
		logic [DATA_W-1:0] result;
		pfc_status_t st;
	} pfc_alu_res_t;

endpackage

// file: verification/pfc_core_sva.sv
// Port checker of the program-flow core
`timescale 1ns/1ps
`default_nettype none
module pfc_core_sva #(
	parameter logic [pfc_pkg::PC_W-1:0] INT_VECTOR =
		pfc_pkg::INT_VECTOR_DEFAULT
) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [3:0] phase_clocks_out,
	input wire logic [pfc_pkg::PC_W-1:0] pmem_addr_out,
	input wire logic int_ack_out,
	input wire logic stack_full_out,
	input wire logic [pfc_pkg::BUS_ADDR_W-1:0] bus_addr_in,
	input wire logic bus_rd_in,
	input wire logic [pfc_pkg::DATA_W-1:0] bus_rdata_out
);
	import pfc_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// Rest of one instruction cycle after the fetch phase, then the next fetch phase
	sequence s_turn;
		phase_clocks_out[1] ##1 phase_clocks_out[2]
		##1 phase_clocks_out[3] ##1 phase_clocks_out[0];
	endsequence
	// Phase strobes never overlap
	a_phase_onehot: assert property ($onehot(phase_clocks_out))
		else $error("phase strobes overlap");
	a_phase_turn: assert property (phase_clocks_out[0] |=> s_turn)
		else $error("phase order broken");
	// Counter moves only at the end of the fetch or last phase
	a_pc_hold: assert property (
		(phase_clocks_out[1] || phase_clocks_out[2])
		|=> $stable(pmem_addr_out))
		else $error("counter moved mid cycle");
	a_pc_step: assert property (phase_clocks_out[0]
		|=> pmem_addr_out == $past(pmem_addr_out) + 12'h001)
		else $error("counter did not step after fetch");
	// Reset needs its own view, so it is not disabled by itself
	a_reset_home: assert property (disable iff (1'b0) reset_in
		|=> pmem_addr_out == PC_RESET && phase_clocks_out == 4'h1
		&& !stack_full_out && !int_ack_out)
		else $error("reset state wrong");
	a_ack_vector: assert property (int_ack_out
		|-> $past(phase_clocks_out[3]) && pmem_addr_out == INT_VECTOR)
		else $error("acknowledge without vector load");
	a_full_no_ack: assert property (stack_full_out
		&& phase_clocks_out[3] |=> !int_ack_out)
		else $error("acknowledge with full stack");
	// Counter is steady across T2 and T3, so either read point agrees
	a_pcl_read: assert property (bus_rd_in
		&& bus_addr_in == IDX_PC_LOW_BYTE
		&& (phase_clocks_out[1] || phase_clocks_out[2])
		|=> bus_rdata_out == pmem_addr_out[7:0])
		else $error("low byte read wrong");
	a_rdata_idle: assert property (!bus_rd_in |=> bus_rdata_out == BYTE_RESET)
		else $error("read data not cleared");
endmodule
bind pfc_core pfc_core_sva #(.INT_VECTOR(INT_VECTOR)) u_sva (
	.mclk_in(mclk_in),
	.reset_in(reset_in),
	.phase_clocks_out(phase_clocks_out),
	.pmem_addr_out(pmem_addr_out),
	.int_ack_out(int_ack_out),
	.stack_full_out(stack_full_out),
	.bus_addr_in(bus_addr_in),
	.bus_rd_in(bus_rd_in),
	.bus_rdata_out(bus_rdata_out)
);
`default_nettype wire

// file: verification/pfc_core_tb.sv
// Self-checking bench of the program-flow core
`timescale 1ns/1ps
`default_nettype none
module pfc_core_tb;
	import pfc_pkg::*;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] phase;
	logic [PC_W-1:0] addr;
	logic [15:0] word;
	logic int_req = 1'b0;
	logic ack;
	logic full;
	logic [BUS_ADDR_W-1:0] b_addr = 4'h0;
	logic [DATA_W-1:0] b_wdata = 8'h00;
	logic b_wr = 1'b0;
	logic b_rd = 1'b0;
	logic [DATA_W-1:0] b_rdata;
	int bad_count = 0;
	int checks_done = 0;
	// 125 MHz clock
	always #4 mclk_in = ~mclk_in;
	pfc_core uut (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.phase_clocks_out(phase),
		.pmem_addr_out(addr),
		.pmem_data_in(word),
		.int_req_in(int_req),
		.int_ack_out(ack),
		.stack_full_out(full),
		.bus_addr_in(b_addr),
		.bus_wdata_in(b_wdata),
		.bus_wr_in(b_wr),
		.bus_rd_in(b_rd),
		.bus_rdata_out(b_rdata)
	);
	pfc_pmem_model mem (
		.addr_in(addr),
		.data_out(word)
	);
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Reset held for six edges; returns just after release
	task automatic start();
		@(posedge mclk_in);
		reset_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		reset_in <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		b_wr <= 1'b1;
		b_addr <= a;
		b_wdata <= d;
		@(posedge mclk_in);
		b_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		b_rd <= 1'b1;
		b_addr <= a;
		@(posedge mclk_in);
		b_rd <= 1'b0;
		#1 v = b_rdata;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, string w);
		logic [7:0] v;
		rd(a, v);
		check(w, v, e);
	endtask
	// Jump, call and return seen in the fetch address trace
	task automatic t_flow();
		logic [11:0] exp [10] = '{12'h000, 12'h001, 12'h002, 12'h008,
			12'h009, 12'h010, 12'h011, 12'h012, 12'h009, 12'h00a};
		mem.wipe();
		mem.rom[0] = 16'h2005;
		mem.rom[1] = 16'h3008;
		mem.rom[2] = 16'h20ee;
		mem.rom[8] = 16'h4010;
		mem.rom[9] = 16'h20aa;
		mem.rom[10] = 16'h300a;
		mem.rom[16] = 16'h2033;
		mem.rom[17] = 16'h5000;
		start();
		check("phase", phase, 4'h1);
		check("stack full", full, 1'b0);
		for (int i = 0; i < 10; i++) begin
			check("fetch", addr, exp[i]);
			repeat (4) @(posedge mclk_in);
			#1;
		end
		rdc(IDX_ACC, 8'haa, "acc");
		rdc(IDX_CTRL, 8'h00, "ctrl");
		rdc(4'h9, 8'h00, "unmapped");
		$display("test flow done");
	endtask
	// Skips, then a low byte write from page one
	task automatic t_skip();
		logic [7:0] v;
		mem.wipe();
		mem.rom[0] = 16'h2000;
		mem.rom[1] = 16'h700f;
		mem.rom[2] = 16'h2011;
		mem.rom[3] = 16'h710f;
		mem.rom[4] = 16'h2022;
		mem.rom[5] = 16'h3105;
		mem.rom[12'h106] = 16'h3105;
		mem.rom[12'h120] = 16'h2077;
		mem.rom[12'h121] = 16'h3121;
		start();
		repeat (60) @(posedge mclk_in);
		rdc(IDX_ACC, 8'h11, "acc skip");
		wr(4'h9, 8'hff);
		wr(IDX_PC_LOW_BYTE, 8'h20);
		repeat (40) @(posedge mclk_in);
		rdc(IDX_ACC, 8'h77, "acc page");
		for (int i = 0; i < 4; i++) begin
			rd(IDX_PC_LOW_BYTE, v);
			check("low byte", v >= 8'h21 && v <= 8'h23, 1'b1);
			@(posedge mclk_in);
		end
		check("page", addr[11:8], 4'h1);
		rdc(4'h9, 8'h00, "unmapped");
		$display("test skip done");
	endtask
	// Add through the low byte alias: carry and half carry set, no zero
	task automatic t_alu();
		mem.wipe();
		mem.rom[0] = 16'h20ff;
		mem.rom[1] = 16'h100f;
		mem.rom[2] = 16'h3002;
		start();
		repeat (20) @(posedge mclk_in);
		rdc(IDX_ACC, 8'h02, "alu sum");
		rdc(IDX_STATUS, 8'h03, "alu flags");
		$display("test alu done");
	endtask
	// Eight nested calls, held request, then overflow call
	task automatic t_irq();
		int n;
		logic seen;
		mem.wipe();
		for (int k = 0; k < 8; k++) begin
			mem.rom[k * 16] = 16'h4000 | 16'((k + 1) * 16);
		end
		mem.rom[12'h072] = 16'h3071;
		mem.rom[12'h08c] = 16'h5000;
		mem.rom[4] = 16'h40a0;
		mem.rom[5] = 16'h2066;
		mem.rom[6] = 16'h3006;
		mem.rom[12'h0a0] = 16'h5000;
		start();
		wr(IDX_CTRL, 8'h01);
		n = 0;
		while (full !== 1'b1 && n < 200) begin
			@(posedge mclk_in);
			#1 n++;
		end
		check("full", full, 1'b1);
		@(posedge mclk_in);
		int_req <= 1'b1;
		@(posedge mclk_in);
		int_req <= 1'b0;
		seen = 1'b0;
		repeat (30) begin
			@(posedge mclk_in);
			#1 seen |= (ack === 1'b1);
		end
		check("ack held", seen, 1'b0);
		rdc(IDX_CTRL, 8'h07, "ctrl held");
		n = 0;
		while (ack !== 1'b1 && n < 100) begin
			@(posedge mclk_in);
			#1 n++;
		end
		check("ack", ack, 1'b1);
		rdc(IDX_CTRL, 8'h04, "ctrl ack");
		repeat (60) @(posedge mclk_in);
		rdc(IDX_ACC, 8'h66, "acc overflow");
		$display("test irq done");
	endtask
	// Main sequence
	initial begin
		t_flow();
		t_alu();
		t_skip();
		t_irq();
		final_report();
	end
	// Watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire

// file: verification/pfc_pmem_model.sv
// Program memory model answering the core's fetch address
`timescale 1ns/1ps
`default_nettype none
module pfc_pmem_model (
	input wire logic [pfc_pkg::PC_W-1:0] addr_in,
	output logic [15:0] data_out
);
	import pfc_pkg::*;
	// Full page set, so any redirect lands on a defined word
	logic [15:0] rom [1 << PC_W];
	// Fill with no-operation words
	task automatic wipe();
		for (int i = 0; i < (1 << PC_W); i++) begin
			rom[i] = WORD_RESET;
		end
	endtask
	// Combinational read, word valid for the whole fetch phase
	assign data_out = rom[addr_in];
endmodule
`default_nettype wire
